// file: cpc_pkg.sv
package cpc_pkg;

	// ----------------------------------------
	// Widths and layout
	// ----------------------------------------
	localparam int ADDR_W      = 24;
	localparam int WORD_W      = 32;
	localparam int MOD_W       = 4;
	localparam int LOW_W       = 13;
	localparam int PBASE_W     = ADDR_W - LOW_W;
	localparam int ELEM_N      = 22;
	localparam int CPU_BASE    = 3;
	localparam int INH_W       = 5;
	localparam int KEY_W       = 4;
	localparam int KEY_LSB     = 0;
	localparam int PBASE_LSB   = 4;
	localparam int COMM_W      = 29;
	localparam int STATE_LSB   = 29;
	localparam int STATE3_BIT  = 31;
	localparam int SEL_INH_LSB = 22;
	localparam int SPM_W       = 4;
	localparam int DLY_W       = 16;

	// ----------------------------------------
	// State codes and reset values
	// ----------------------------------------
	localparam logic [2:0]        ST0        = 3'h0;
	localparam logic [2:0]        ST1        = 3'h1;
	localparam logic [2:0]        ST2        = 3'h2;
	localparam logic [2:0]        ST3        = 3'h6;
	localparam logic [WORD_W-1:0] CSR_RST    = {ST2, {COMM_W{1'b1}}};
	localparam logic [WORD_W-1:0] BUSY_CODE  = 32'hFFFFFFFF;
	localparam logic [4:0]        LD_ST_COMM = 5'h18;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS   = 10;
	localparam int UCYC_NS  = 300;
	localparam int UCYC_CYC = (UCYC_NS / CLK_NS < 1) ? 1 : UCYC_NS / CLK_NS;

	typedef enum logic [3:0] {
		OP_LD_SELF, OP_LD_EXT, OP_STORE, OP_GO_S3, OP_PWR_DN, OP_PWR_UP,
		OP_LD_KEY, OP_ST_KEY, OP_EST_PROT, OP_TAS, OP_DELAY, OP_ST_ID
	} cpc_op_e;

endpackage : cpc_pkg

// file: cpc_xl_if.sv
`timescale 1ns/10ps
interface cpc_xl_if;
	import cpc_pkg::*;
	logic [ADDR_W-1:0] log_addr;
	logic [ADDR_W-1:0] phys_addr;
	logic [WORD_W-1:0] tr1;
	logic [WORD_W-1:0] tr2;
	logic [WORD_W-1:0] pref;
	logic              pref_hit;
	logic              invalid;
	modport ctrl (output log_addr, tr1, tr2, pref, input phys_addr, pref_hit, invalid);
	modport xl   (input log_addr, tr1, tr2, pref, output phys_addr, pref_hit, invalid);
endinterface : cpc_xl_if

// file: cpc_xlate.sv
`timescale 1ns/10ps
module cpc_xlate (
	// Clock and reset for checks
	input wire logic mclk,
	input wire logic sys_rst,
	// Translation link
	cpc_xl_if.xl     xl
);
	import cpc_pkg::*;

	// ----------------------------------------
	// Logical split
	// ----------------------------------------
	wire logic [MOD_W-1:0]        lmod;
	wire logic [ADDR_W-MOD_W-1:0] loff;
	wire logic [WORD_W-1:0]       map_word;
	wire logic [MOD_W-1:0]        pmod;

	assign lmod        = xl.log_addr[ADDR_W-1 -: MOD_W];
	assign loff        = xl.log_addr[ADDR_W-MOD_W-1:0];
	assign xl.pref_hit = (lmod == '0);
	assign xl.invalid  = xl.pref_hit && (loff[ADDR_W-MOD_W-1:LOW_W] != '0);
	assign map_word    = lmod[MOD_W-1] ? xl.tr2 : xl.tr1;
	assign pmod        = map_word[{lmod[MOD_W-2:0], 2'b00} +: MOD_W];
	assign xl.phys_addr = xl.pref_hit ?
		{xl.pref[PBASE_LSB +: PBASE_W], loff[LOW_W-1:0]} : {pmod, loff};

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	chk_pref_upper: assert property (xl.pref_hit |->
		xl.phys_addr[ADDR_W-1:LOW_W] == xl.pref[PBASE_LSB +: PBASE_W]
		&& xl.phys_addr[LOW_W-1:0] == xl.log_addr[LOW_W-1:0])
		else $error("preferential address not formed from base and offset");
	chk_pref_over: assert property ((xl.log_addr[ADDR_W-1 -: MOD_W] == '0
		&& xl.log_addr[ADDR_W-MOD_W-1:LOW_W] != '0) |-> xl.invalid)
		else $error("preferential overflow not flagged");

endmodule : cpc_xlate

// file: cpc_ctrl.sv
`timescale 1ns/10ps
module cpc_ctrl (
	// Clock and reset
	input  wire logic                           mclk,
	input  wire logic                           sys_rst,
	// Instruction request
	input  wire logic                           instr_valid,
	input  wire cpc_pkg::cpc_op_e               instr_op,
	input  wire logic [cpc_pkg::SPM_W-1:0]      instr_a,
	input  wire logic [cpc_pkg::INH_W-1:0]      instr_d,
	input  wire logic [cpc_pkg::DLY_W-1:0]      instr_count,
	input  wire logic [cpc_pkg::ADDR_W-1:0]     eff_addr,
	input  wire logic [cpc_pkg::WORD_W-1:0]     store_data,
	input  wire logic [cpc_pkg::KEY_W-1:0]      key_in,
	input  wire logic                           privileged,
	input  wire logic                           stop_exit,
	input  wire logic                           peer_s3,
	input  wire logic [1:0]                     slot_pin,
	// Instruction answer
	output logic                                instr_done,
	output logic                                illegal_op,
	output logic                                addr_invalid,
	output logic                                key_fault,
	output logic [1:0]                          ic_step,
	output logic                                fetch_go,
	output logic [2:0]                          state_out,
	output logic                                reconfig_ind,
	output logic [cpc_pkg::KEY_W-1:0]           mem_key,
	// Scratchpad
	output logic [cpc_pkg::SPM_W-1:0]           spm_idx,
	input  wire logic [cpc_pkg::WORD_W-1:0]     spm_rdata,
	// Memory bus
	output logic                                mem_req,
	output logic                                mem_we,
	output logic                                mem_lock,
	output logic                                mem_key_area,
	output logic [cpc_pkg::ADDR_W-1:0]          mem_addr,
	output logic [cpc_pkg::WORD_W-1:0]          mem_wdata,
	input  wire logic [cpc_pkg::WORD_W-1:0]     mem_rdata,
	input  wire logic                           mem_ack,
	input  wire logic                           mem_key_viol,
	// Direct control lines
	output logic [cpc_pkg::ELEM_N-1:0]          ext_sel,
	output logic [cpc_pkg::INH_W-1:0]           ext_ld,
	output logic [1:0]                          ext_idx,
	output logic [cpc_pkg::WORD_W-1:0]          ext_data,
	input  wire logic [cpc_pkg::WORD_W-1:0]     ext_rdata,
	input  wire logic [2:0]                     ext_tgt_state,
	output logic                                pwr_up,
	output logic                                pwr_dn
);
	import cpc_pkg::*;

	typedef enum {S_IDLE, S_SELF_RD, S_SELF_WR, S_SEL, S_CHK, S_STW, S_MRD, S_MWR,
		S_DELAY, S_FETCH} cpc_st_e;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	cpc_st_e           st_ff, nxt_st;
	cpc_op_e           op_ff, nxt_op;
	logic [1:0]        cnt_ff, nxt_cnt;
	logic [ADDR_W-1:0] lad_ff, nxt_lad, zl_ff, nxt_zl;
	logic [WORD_W-1:0] mq_ff, nxt_mq, tr1_ff, nxt_tr1, tr2_ff, nxt_tr2;
	logic [WORD_W-1:0] pref_ff, nxt_pref, csr_ff, nxt_csr, wd_ff, nxt_wd;
	logic [WORD_W-1:0] xd_ff, nxt_xd;
	logic [ELEM_N-1:0] sel_ff, nxt_sel;
	logic [INH_W-1:0]  inh_ff, nxt_inh, xld_ff, nxt_xld;
	logic [SPM_W-1:0]  spm_ff, nxt_spm;
	logic [DLY_W-1:0]  dly_ff, nxt_dly;
	logic [3:0]        id_ff, nxt_id;
	logic [1:0]        step_ff, nxt_step;
	logic              req_ff, nxt_req, we_ff, nxt_we, lock_ff, nxt_lock, ka_ff, nxt_ka;
	logic              done_ff, nxt_done, ill_ff, nxt_ill, inv_ff, nxt_inv;
	logic              kv_ff, nxt_kv, fch_ff, nxt_fch, pu_ff, nxt_pu, pd_ff, nxt_pd;
	logic [ADDR_W-1:0] addr_ff;
	logic              bad_ff;
	logic [1:0]        slot_s1_ff, slot_s2_ff, slot_s3_ff, slot_ff;
	logic [7:0]        div_ff;

	cpc_xl_if xl ();
	cpc_xlate u_xlate (.mclk(mclk), .sys_rst(sys_rst), .xl(xl.xl));

	// ----------------------------------------
	// Decode wires
	// ----------------------------------------
	wire logic [2:0]        cur_state;
	wire logic              in_s3, go_ok, uc_tick, sel_onehot, self_hit, ld_bad;
	wire logic [ELEM_N-1:0] sel_word, own_bit;
	wire logic [WORD_W-1:0] self_word, st_src;
	wire logic [INH_W-1:0]  word_mask;

	assign cur_state  = csr_ff[STATE_LSB +: 3];
	assign in_s3      = csr_ff[STATE3_BIT];
	assign go_ok      = (cur_state == ST2 && !peer_s3) || cur_state == ST3;
	assign uc_tick    = (div_ff == 8'(UCYC_CYC - 1));
	assign sel_word   = spm_rdata[ELEM_N-1:0];
	assign own_bit    = ELEM_N'(1) << (CPU_BASE + slot_ff);
	assign self_hit   = (sel_ff & own_bit) != '0;
	assign sel_onehot = sel_ff != '0 && (sel_ff & (sel_ff - 1'b1)) == '0;
	assign ld_bad     = !sel_onehot || self_hit || !in_s3;
	assign word_mask  = (cnt_ff == 2'd3) ? LD_ST_COMM : (INH_W'(1) << cnt_ff);
	assign self_word  = (cnt_ff == 2'd0) ? tr1_ff : (cnt_ff == 2'd1) ? tr2_ff :
		(cnt_ff == 2'd2) ? pref_ff : csr_ff;
	assign st_src     = self_hit ? self_word : ext_rdata;
	assign xl.log_addr = nxt_lad;
	assign xl.tr1     = tr1_ff;
	assign xl.tr2     = tr2_ff;
	assign xl.pref    = pref_ff;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		nxt_st = st_ff; nxt_op = op_ff; nxt_cnt = cnt_ff; nxt_lad = lad_ff; nxt_zl = zl_ff;
		nxt_mq = mq_ff; nxt_tr1 = tr1_ff; nxt_tr2 = tr2_ff; nxt_pref = pref_ff;
		nxt_csr = csr_ff; nxt_wd = wd_ff; nxt_xd = xd_ff; nxt_sel = sel_ff;
		nxt_inh = inh_ff; nxt_spm = spm_ff; nxt_dly = dly_ff; nxt_id = id_ff;
		nxt_step = step_ff; nxt_req = req_ff; nxt_we = we_ff; nxt_lock = lock_ff;
		nxt_ka = ka_ff; nxt_xld = '0; nxt_done = 1'b0; nxt_ill = 1'b0; nxt_inv = 1'b0;
		nxt_kv = 1'b0; nxt_fch = 1'b0; nxt_pu = 1'b0; nxt_pd = 1'b0;
		case (st_ff)
			S_IDLE:
			begin
				nxt_cnt = '0; nxt_step = 2'd1; nxt_ka = 1'b0;
				if (stop_exit)
				begin
					nxt_lad = '0; nxt_req = 1'b1; nxt_we = 1'b0; nxt_st = S_FETCH;
				end
				else if (instr_valid)
				begin
					nxt_op = instr_op; nxt_inh = instr_d; nxt_spm = instr_a; nxt_zl = eff_addr;
					case (instr_op)
						OP_LD_SELF: nxt_st = S_SELF_RD;
						OP_LD_EXT, OP_STORE, OP_PWR_DN, OP_PWR_UP: nxt_st = S_SEL;
						OP_GO_S3:
						begin
							nxt_done = 1'b1; nxt_ill = !go_ok;
							if (go_ok) nxt_csr[STATE_LSB +: 3] = ST3;
						end
						OP_LD_KEY:
						begin
							nxt_pref[KEY_LSB +: KEY_W] = key_in; nxt_done = 1'b1;
						end
						OP_ST_KEY, OP_EST_PROT, OP_ST_ID:
						begin
							nxt_lad = eff_addr; nxt_we = 1'b1; nxt_st = S_MWR; nxt_req = 1'b1;
							nxt_wd = WORD_W'(pref_ff[KEY_LSB +: KEY_W]);
							if (instr_op == OP_ST_ID)
							begin
								nxt_id = 4'h1 << slot_ff; nxt_wd = WORD_W'(nxt_id);
							end
							if (instr_op == OP_EST_PROT)
							begin
								nxt_wd = store_data; nxt_ka = privileged;
								if (!privileged)
								begin
									nxt_req = 1'b0; nxt_ill = 1'b1; nxt_done = 1'b1;
									nxt_st = S_IDLE;
								end
							end
						end
						OP_TAS:
						begin
							nxt_lad = eff_addr; nxt_we = 1'b0; nxt_req = 1'b1;
							nxt_lock = 1'b1; nxt_st = S_MRD;
						end
						OP_DELAY:
						begin
							nxt_dly = instr_count; nxt_st = S_DELAY;
						end
						default:
						begin
							nxt_ill = 1'b1; nxt_done = 1'b1;
						end
					endcase
				end
			end
			S_SELF_RD:
			begin
				nxt_mq = spm_rdata; nxt_st = S_SELF_WR;
			end
			S_SELF_WR:
			begin
				case (cnt_ff)
					2'd0: if (!inh_ff[0]) nxt_tr1 = mq_ff;
					2'd1: if (!inh_ff[1]) nxt_tr2 = mq_ff;
					2'd2: if (!inh_ff[2]) nxt_pref = mq_ff;
					default:
					begin
						if (!inh_ff[3]) nxt_csr[STATE_LSB +: 3] = mq_ff[STATE_LSB +: 3];
						if (!inh_ff[4]) nxt_csr[COMM_W-1:0] = mq_ff[COMM_W-1:0];
					end
				endcase
				nxt_cnt = cnt_ff + 2'd1; nxt_spm = spm_ff + 1'b1; nxt_st = S_SELF_RD;
				if (cnt_ff == 2'd3)
				begin
					nxt_done = 1'b1; nxt_st = S_IDLE;
				end
			end
			S_SEL:
			begin
				nxt_sel = sel_word; nxt_inh = spm_rdata[SEL_INH_LSB +: INH_W]; nxt_st = S_CHK;
			end
			S_CHK:
			begin
				nxt_st = S_IDLE; nxt_done = 1'b1;
				case (op_ff)
					OP_LD_EXT:
						if (ld_bad) nxt_ill = 1'b1;
						else
						begin
							nxt_done = 1'b0; nxt_lad = zl_ff; nxt_we = 1'b0; nxt_req = 1'b1;
							nxt_st = S_MRD;
						end
					OP_STORE:
						if (!sel_onehot || !(in_s3 || self_hit)) nxt_ill = 1'b1;
						else
						begin
							nxt_done = 1'b0; nxt_st = S_STW;
						end
					OP_PWR_DN:
						if (!sel_onehot || self_hit || !in_s3 || ext_tgt_state != ST1)
							nxt_ill = 1'b1;
						else nxt_pd = 1'b1;
					default:
						if (!sel_onehot || self_hit || !in_s3) nxt_ill = 1'b1;
						else nxt_pu = 1'b1;
				endcase
			end
			S_STW:
			begin
				nxt_lad = zl_ff + ADDR_W'(cnt_ff); nxt_wd = st_src; nxt_we = 1'b1;
				nxt_req = 1'b1; nxt_st = S_MWR;
			end
			S_MRD, S_MWR, S_FETCH:
				if (bad_ff || mem_ack)
				begin
					nxt_req = 1'b0; nxt_st = S_IDLE; nxt_lock = 1'b0;
					nxt_done = (st_ff != S_FETCH); nxt_fch = (st_ff == S_FETCH);
					nxt_inv = bad_ff; nxt_kv = !bad_ff && mem_key_viol;
					if (!bad_ff && !mem_key_viol && st_ff == S_MRD)
					begin
						if (op_ff == OP_TAS)
						begin
							if (mem_rdata != BUSY_CODE)
							begin
								nxt_done = 1'b0; nxt_lock = 1'b1; nxt_wd = BUSY_CODE;
								nxt_we = 1'b1; nxt_req = 1'b1; nxt_st = S_MWR;
							end
						end
						else
						begin
							nxt_xd = mem_rdata; nxt_xld = word_mask & ~inh_ff;
							if (cnt_ff != 2'd3)
							begin
								nxt_done = 1'b0; nxt_cnt = cnt_ff + 2'd1; nxt_req = 1'b1;
								nxt_lad = zl_ff + ADDR_W'(nxt_cnt); nxt_st = S_MRD;
							end
						end
					end
					if (!bad_ff && !mem_key_viol && st_ff == S_MWR)
					begin
						if (op_ff == OP_TAS) nxt_step = 2'd2;
						if (op_ff == OP_STORE && cnt_ff != 2'd3)
						begin
							nxt_done = 1'b0; nxt_cnt = cnt_ff + 2'd1; nxt_st = S_STW;
						end
					end
				end
			default:
				if (dly_ff == '0 && uc_tick)
				begin
					nxt_done = 1'b1; nxt_st = S_IDLE;
				end
				else if (uc_tick) nxt_dly = dly_ff - 1'b1;
		endcase
	end

	// ----------------------------------------
	// Flops
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		{slot_s1_ff, slot_s2_ff, slot_s3_ff} <= {slot_pin, slot_s1_ff, slot_s2_ff};
		addr_ff <= xl.phys_addr;
		bad_ff  <= xl.invalid;
		if (sys_rst)
		begin
			st_ff <= S_IDLE; op_ff <= OP_LD_SELF; cnt_ff <= '0; lad_ff <= '0; zl_ff <= '0;
			mq_ff <= '0; tr1_ff <= '0; tr2_ff <= '0; pref_ff <= '0; csr_ff <= CSR_RST;
			wd_ff <= '0; xd_ff <= '0; sel_ff <= '0; inh_ff <= '0; spm_ff <= '0;
			dly_ff <= '0; id_ff <= '0; step_ff <= 2'd1; req_ff <= 1'b0; we_ff <= 1'b0;
			lock_ff <= 1'b0; ka_ff <= 1'b0; xld_ff <= '0; done_ff <= 1'b0; ill_ff <= 1'b0;
			inv_ff <= 1'b0; kv_ff <= 1'b0; fch_ff <= 1'b0; pu_ff <= 1'b0; pd_ff <= 1'b0;
			slot_ff <= '0; div_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st; op_ff <= nxt_op; cnt_ff <= nxt_cnt; lad_ff <= nxt_lad;
			zl_ff <= nxt_zl; mq_ff <= nxt_mq; tr1_ff <= nxt_tr1; tr2_ff <= nxt_tr2;
			pref_ff <= nxt_pref; csr_ff <= nxt_csr; wd_ff <= nxt_wd; xd_ff <= nxt_xd;
			sel_ff <= nxt_sel; inh_ff <= nxt_inh; spm_ff <= nxt_spm; dly_ff <= nxt_dly;
			id_ff <= nxt_id; step_ff <= nxt_step; req_ff <= nxt_req; we_ff <= nxt_we;
			lock_ff <= nxt_lock; ka_ff <= nxt_ka; xld_ff <= nxt_xld; done_ff <= nxt_done;
			ill_ff <= nxt_ill; inv_ff <= nxt_inv; kv_ff <= nxt_kv; fch_ff <= nxt_fch;
			pu_ff <= nxt_pu; pd_ff <= nxt_pd;
			if (slot_s2_ff == slot_s3_ff) slot_ff <= slot_s3_ff;
			div_ff <= uc_tick ? '0 : div_ff + 8'd1;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign instr_done   = done_ff;
	assign illegal_op   = ill_ff;
	assign addr_invalid = inv_ff;
	assign key_fault    = kv_ff;
	assign ic_step      = step_ff;
	assign fetch_go     = fch_ff;
	assign state_out    = cur_state;
	assign reconfig_ind = in_s3;
	assign mem_key      = pref_ff[KEY_LSB +: KEY_W];
	assign spm_idx      = spm_ff;
	assign mem_req      = req_ff && !bad_ff;
	assign mem_we       = we_ff;
	assign mem_lock     = lock_ff;
	assign mem_key_area = ka_ff;
	assign mem_addr     = addr_ff;
	assign mem_wdata    = wd_ff;
	assign ext_sel      = sel_ff;
	assign ext_ld       = xld_ff;
	assign ext_idx      = cnt_ff;
	assign ext_data     = xd_ff;
	assign pwr_up       = pu_ff;
	assign pwr_dn       = pd_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	wire logic idle_go;
	assign idle_go = st_ff == S_IDLE && instr_valid && !stop_exit;

	sequence s_stop_seen;
		st_ff == S_IDLE && stop_exit;
	endsequence
	sequence s_zero_read;
		mem_req && lad_ff == '0 && !mem_we
		&& mem_addr == {pref_ff[PBASE_LSB +: PBASE_W], {LOW_W{1'b0}}} ##0 (st_ff == S_FETCH);
	endsequence

	chk_ext_state3: assert property (ext_ld != '0 |-> in_s3)
		else $error("external load outside state 3");
	chk_ext_notself: assert property (ext_ld != '0 |-> (ext_sel & own_bit) == '0)
		else $error("external load hit own element");
	chk_pwrdn_halt: assert property (pwr_dn |-> $past(ext_tgt_state) == ST1 && in_s3)
		else $error("power down without halted target");
	chk_pwrup_s3: assert property (pwr_up |-> in_s3 && $onehot(ext_sel))
		else $error("power up outside state 3");
	chk_go_refuse: assert property (idle_go && instr_op == OP_GO_S3 && !go_ok
		|=> illegal_op && instr_done && $stable(csr_ff))
		else $error("state 3 entry not refused");
	chk_go_enter: assert property (idle_go && instr_op == OP_GO_S3 && go_ok
		|=> state_out == ST3 && reconfig_ind)
		else $error("state 3 not entered");
	chk_tas_busy: assert property (st_ff == S_MRD && op_ff == OP_TAS && mem_ack
		&& !bad_ff && !mem_key_viol && mem_rdata == BUSY_CODE
		|=> instr_done && ic_step == 2'd1 && !mem_lock)
		else $error("busy lock not skipped by one");
	chk_tas_free: assert property (st_ff == S_MRD && op_ff == OP_TAS && mem_ack
		&& !bad_ff && !mem_key_viol && mem_rdata != BUSY_CODE
		|=> mem_we && mem_lock && mem_wdata == BUSY_CODE && mem_req)
		else $error("free lock not written busy");
	chk_fetch_zero: assert property (s_stop_seen |=> s_zero_read)
		else $error("fetch after stop not at zero");
	chk_prot_priv: assert property (idle_go && instr_op == OP_EST_PROT && !privileged
		|=> illegal_op && !mem_req && !mem_key_area)
		else $error("protection write without privilege");
	chk_ident_bit: assert property (idle_go && instr_op == OP_ST_ID
		|=> $onehot(id_ff) && mem_wdata == WORD_W'(id_ff))
		else $error("identity not one slot bit");
	chk_delay_hold: assert property (st_ff == S_DELAY && dly_ff != '0 |=> !instr_done)
		else $error("delay ended early");

endmodule : cpc_ctrl

// file: cpc_mem_model.sv
`timescale 1ns/10ps
module cpc_mem_model (
	// Clock, reset, pacing
	input  wire logic                         mclk,
	input  wire logic                         sys_rst,
	input  wire logic [3:0]                   wait_cyc,
	// Memory bus
	input  wire logic                         mem_req,
	input  wire logic                         mem_we,
	input  wire logic                         mem_lock,
	input  wire logic [cpc_pkg::KEY_W-1:0]    mem_key,
	input  wire logic [cpc_pkg::ADDR_W-1:0]   mem_addr,
	input  wire logic [cpc_pkg::WORD_W-1:0]   mem_wdata,
	output logic      [cpc_pkg::WORD_W-1:0]   mem_rdata,
	output logic                              mem_ack,
	output logic                              mem_key_viol,
	// Scratchpad and targets
	input  wire logic [cpc_pkg::SPM_W-1:0]    spm_idx,
	output logic      [cpc_pkg::WORD_W-1:0]   spm_rdata,
	output logic      [cpc_pkg::WORD_W-1:0]   ext_rdata,
	output logic      [2:0]                   ext_tgt_state
);
	import cpc_pkg::*;
	localparam logic [KEY_W-1:0] PROT_KEY = 4'h5;
	logic [WORD_W-1:0] mem [256];
	logic [WORD_W-1:0] scratchpad_memory [16];
	logic [3:0]        cnt_ff;
	logic              held_ff;
	wire logic         stall, prot_hit;
	assign spm_rdata     = scratchpad_memory[spm_idx];
	assign ext_rdata     = ~mem_rdata;
	assign ext_tgt_state = scratchpad_memory[15][2:0];
	assign stall         = cnt_ff < wait_cyc || (held_ff && !mem_lock);
	assign prot_hit      = mem_addr[7:6] == 2'h3 && mem_key != PROT_KEY;
	// ----------------------------------------
	// Memory answer, prompt or slow
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		mem_ack      <= 1'b0;
		mem_key_viol <= 1'b0;
		mem_rdata    <= ~mem_rdata;
		cnt_ff       <= 4'h0;
		held_ff      <= held_ff && mem_lock;
		if (sys_rst)
		begin
			mem_rdata <= 32'h5A5A5A5A;
			held_ff   <= 1'b0;
			for (int i = 0; i < 256; i++)
				mem[i] <= 32'h00000000;
		end
		else if (mem_req && !mem_ack && stall)
			cnt_ff <= cnt_ff + 4'h1;
		else if (mem_req && !mem_ack)
		begin
			mem_ack      <= 1'b1;
			mem_key_viol <= prot_hit;
			held_ff      <= mem_lock && !mem_we;
			if (!prot_hit)
				mem_rdata <= mem[mem_addr[7:0]];
			if (mem_we && !prot_hit)
				mem[mem_addr[7:0]] <= mem_wdata;
		end
	end
endmodule : cpc_mem_model

// file: test_cpu_config_protect_control.sv
`timescale 1ns/10ps
module test_cpu_config_protect_control;
	import cpc_pkg::*;
	logic mclk, sys_rst, instr_valid, privileged, stop_exit, peer_s3;
	logic instr_done, illegal_op, addr_invalid, fetch_go, reconfig_ind;
	logic pwr_up, mem_req, mem_we, mem_ack, ill, inv, got_pwr;
	logic pwr_dn, mem_lock, mem_key_viol, key_fault, kv, got_dn;
	cpc_op_e             instr_op;
	logic [SPM_W-1:0]    instr_a, spm_idx;
	logic [INH_W-1:0]    instr_d, ext_ld, xld;
	logic [DLY_W-1:0]    instr_count;
	logic [ADDR_W-1:0]   eff_addr, mem_addr, last_addr;
	logic [WORD_W-1:0]   store_data, mem_wdata, mem_rdata, spm_rdata, ext_rdata;
	logic [WORD_W-1:0]   ext_data, last_xd;
	logic [KEY_W-1:0]    key_in, mem_key;
	logic [1:0]          slot_pin, ic_step, step;
	logic [2:0]          state_out, ext_tgt_state;
	logic [3:0]          wait_cyc;
	int                  err_count, num_checks, cyc;
	cpc_ctrl cpc_ctrl_i (.*, .mem_key_area(), .ext_sel(), .ext_idx());
	cpc_mem_model cpc_mem_model_i (.*);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_end(input bit fetch);
		got_pwr = 1'b0;
		got_dn  = 1'b0;
		xld     = '0;
		#1;
		for (cyc = 0; (fetch ? fetch_go : instr_done) !== 1'b1; cyc++)
		begin
			@(posedge mclk);
			#1;
			got_pwr |= pwr_up;
			got_dn  |= pwr_dn;
			xld     |= ext_ld;
			if (ext_ld != '0)
				last_xd = ext_data;
			if (mem_req === 1'b1)
				last_addr = mem_addr;
			if (cyc > 3000)
			begin
				err_count++;
				print_verdict();
			end
		end
		ill  = illegal_op;
		inv  = addr_invalid;
		step = ic_step;
		kv   = key_fault;
		@(posedge mclk);
	endtask : wait_end
	task automatic do_op(input cpc_op_e op, input logic [3:0] a, input logic [ADDR_W-1:0] z);
		instr_op    <= op;
		instr_a     <= a;
		eff_addr    <= z;
		instr_valid <= 1'b1;
		@(posedge mclk);
		instr_valid <= 1'b0;
		wait_end(1'b0);
	endtask : do_op
	// ----------------------------------------
	// Clock and sequence
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		{instr_valid, privileged, stop_exit, peer_s3, instr_a, instr_d} = '0;
		{instr_count, eff_addr, store_data, key_in, wait_cyc} = '0;
		{err_count, num_checks} = '0;
		instr_op = OP_GO_S3;
		slot_pin = 2'h1;
		sys_rst  = 1'b1;
		cpc_mem_model_i.scratchpad_memory[0] = 32'h00000001;
		cpc_mem_model_i.scratchpad_memory[7] = {ST2, 29'h0};
		cpc_mem_model_i.scratchpad_memory[1] = 32'h00000010;
		cpc_mem_model_i.scratchpad_memory[2] = 32'h00800001;
		cpc_mem_model_i.scratchpad_memory[15] = {29'h0, ST2};
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		#1;
		check(32'(state_out), 32'(ST2));
		@(posedge mclk);
		do_op(OP_ST_ID, 4'h0, 24'h000020);
		check(cpc_mem_model_i.mem[32], 32'h00000002);
		wait_cyc <= 4'h3;
		do_op(OP_TAS, 4'h0, 24'h000010);
		check(32'(step), 32'h2);
		check(cpc_mem_model_i.mem[16], BUSY_CODE);
		do_op(OP_TAS, 4'h0, 24'h000010);
		check(32'(step), 32'h1);
		check(32'(last_addr), 32'h00000010);
		wait_cyc <= 4'h0;
		do_op(OP_TAS, 4'h0, 24'h002000);
		check(32'(inv), 32'h1);
		do_op(OP_EST_PROT, 4'h0, 24'h000040);
		check(32'(ill), 32'h1);
		do_op(OP_LD_EXT, 4'h0, 24'h000040);
		check(32'({ill, state_out}), 32'({1'b1, ST2}));
		do_op(OP_PWR_UP, 4'h0, 24'h0);
		check(32'({ill, got_pwr}), 32'h2);
		do_op(OP_GO_S3, 4'h0, 24'h0);
		check(32'({ill, reconfig_ind, state_out}), 32'({2'b01, ST3}));
		do_op(OP_PWR_DN, 4'h0, 24'h0);
		check(32'(ill), 32'h1);
		cpc_mem_model_i.scratchpad_memory[15] <= {29'h0, ST1};
		do_op(OP_PWR_DN, 4'h0, 24'h0);
		check(32'({ill, got_dn}), 32'h1);
		do_op(OP_PWR_UP, 4'h0, 24'h0);
		check(32'({ill, got_pwr}), 32'h1);
		key_in <= 4'hA;
		do_op(OP_LD_KEY, 4'h0, 24'h0);
		check(32'(mem_key), 32'hA);
		do_op(OP_STORE, 4'h1, 24'h000050);
		check(cpc_mem_model_i.mem[82], 32'h0000000A);
		check(cpc_mem_model_i.mem[83], 32'hDFFFFFFF);
		do_op(OP_LD_EXT, 4'h2, 24'h000050);
		check(32'(xld), 32'h1D);
		check(last_xd, 32'hDFFFFFFF);
		do_op(OP_TAS, 4'h0, 24'h0000C0);
		check(32'({kv, step}), 32'h5);
		check(cpc_mem_model_i.mem[192], 32'h00000000);
		instr_count <= 16'h0002;
		do_op(OP_DELAY, 4'h0, 24'h0);
		check(32'(cyc >= 2 * UCYC_CYC && cyc <= 3 * UCYC_CYC + 4), 32'h1);
		instr_d <= 5'h17;
		do_op(OP_LD_SELF, 4'h4, 24'h0);
		check(32'({state_out, mem_key}), 32'({ST2, 4'hA}));
		peer_s3 <= 1'b1;
		do_op(OP_GO_S3, 4'h0, 24'h0);
		check(32'({ill, state_out}), 32'({1'b1, ST2}));
		peer_s3 <= 1'b0;
		stop_exit <= 1'b1;
		@(posedge mclk);
		stop_exit <= 1'b0;
		wait_end(1'b1);
		check(32'(last_addr), 32'h0);
		print_verdict();
	end
endmodule : test_cpu_config_protect_control
